// ==== core/scr_top.sv ====
// Command interpreter for port reset, revision read and VCI change,
// plus the switch reset outputs.
// Assumes command cells arrive already matched, one byte per beat,
// on the system clock; the button is an asynchronous pin.
//
// Overview of operation
// - Port reset code asserts port reset n for each set sub-command bit.
// - Revision code returns a response cell carrying revision in first data byte.
// - Revision byte: upper nibble before the point, lower nibble after it.
// - VCI change code loads the sub-command byte as the control-cell VCI.
// - Manual button asserts both system and controller reset outputs.
// - Global reset asserts system and controller resets, never port resets.
// - Controller reset asserts only that output; ports only by port command.
// - Command code in bits 2..0; bit 7 asks acknowledge, bit 6 poll.
// - Response cells copy the whole command cell; only a revision reply replaces data byte 0.
`timescale 1ns/1ns
`default_nettype none
`include "scr_map.svh"

module scr_top #(
    parameter int RST_HOLD_CYCLES = `SCR_RST_HOLD_CYC,
    parameter int FIFO_DEPTH = `SCR_FIFO_DEPTH,
    parameter int PORTS = 8,
    // Arbitrary revision value, not tied to any real part
    parameter logic [7:0] REVISION = `SCR_REV_VAL
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reset_button_n,
    input wire logic i_cell_valid,
    input wire logic i_cell_sop,
    input wire logic [7:0] i_cell_byte,
    output logic o_cell_ready,
    output logic o_rsp_valid,
    output logic o_rsp_sop,
    output logic [7:0] o_rsp_byte,
    input wire logic i_rsp_ready,
    output logic [7:0] o_switch_vci,
    output logic o_system_reset_out,
    output logic o_controller_reset_out,
    output logic [PORTS-1:0] o_port_reset_out
);
    localparam int CW = 16;
    localparam logic [CW-1:0] HOLD = CW'(RST_HOLD_CYCLES);

    // ****************************************
    // Button synchroniser
    // ****************************************
    logic btn_meta_ff;
    logic btn_sync_ff;
    logic button;

    // First stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            btn_meta_ff <= 1'b1;
            btn_sync_ff <= 1'b1;
        end else begin
            btn_meta_ff <= i_reset_button_n;
            btn_sync_ff <= btn_meta_ff;
        end
    end
    assign button = !btn_sync_ff;

    // ****************************************
    // Cell capture and command state machine
    // ****************************************
    scr_pkg::scr_state_e state_ff;
    scr_pkg::scr_state_e nxt_state;
    logic [4:0] idx_ff;
    logic [4:0] nxt_idx;
    logic [7:0] vci_ff;
    logic [7:0] nxt_vci;
    logic ready_ff;
    logic nxt_ready;
    logic [7:0] cell_mem [`SCR_CELL_LEN];
    logic mem_we;
    logic [4:0] mem_addr;
    scr_pkg::scr_cmd_byte_s cmd;
    scr_pkg::scr_rev_s rev;
    logic is_rev;
    logic exec_sys;
    logic exec_ctl;
    logic [PORTS-1:0] exec_port;
    logic want_rsp;
    logic fifo_wr_valid;
    logic fifo_wr_ready;
    scr_pkg::scr_rsp_s fifo_wr_data;
    logic take;

    assign take = i_cell_valid && ready_ff;
    assign cmd = scr_pkg::scr_cmd_byte_s'(cell_mem[`SCR_OFS_CMD]);
    assign rev = scr_pkg::scr_rev_s'(REVISION);
    assign is_rev = (cmd.code == `SCR_CMD_REV);

    // Command decode, acted on for one cycle in the execute state
    always_comb begin
        exec_sys = 1'b0;
        exec_ctl = 1'b0;
        exec_port = '0;
        want_rsp = 1'b0;
        if (state_ff == scr_pkg::ST_EXEC) begin
            case (cmd.code)
                `SCR_CMD_CTL_RST: begin
                    exec_ctl = 1'b1;
                    want_rsp = cmd.ack;
                end
                `SCR_CMD_GLB_RST: begin
                    exec_sys = 1'b1;
                    exec_ctl = 1'b1;
                    want_rsp = cmd.ack;
                end
                `SCR_CMD_PORT_RST: begin
                    exec_port = cell_mem[`SCR_OFS_SUB][PORTS-1:0];
                    want_rsp = cmd.ack;
                end
                `SCR_CMD_REV: begin
                    want_rsp = 1'b1;
                end
                `SCR_CMD_VCI: begin
                    want_rsp = cmd.ack;
                end
                default: begin
                    // Codes 0 to 2 do nothing and send no reply
                    want_rsp = 1'b0;
                end
            endcase
        end
    end

    // Response byte: copy of the cell, data0 swapped for revision
    always_comb begin
        fifo_wr_data.sop = (idx_ff == 5'd0);
        fifo_wr_data.data = cell_mem[idx_ff];
        if (is_rev && idx_ff == `SCR_OFS_DATA0) begin
            fifo_wr_data.data = rev;
        end
        fifo_wr_valid = (state_ff == scr_pkg::ST_TX);
    end

    // Capture writes: a start byte always restarts the cell
    always_comb begin
        mem_we = take && (i_cell_sop || idx_ff != 5'd0);
        mem_addr = i_cell_sop ? 5'd0 : idx_ff;
    end

    // State, index, VCI and input ready next values
    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_vci = vci_ff;
        nxt_ready = ready_ff;
        case (state_ff)
            scr_pkg::ST_RX: begin
                if (mem_we) begin
                    if (mem_addr == `SCR_CELL_LEN - 5'd1) begin
                        nxt_state = scr_pkg::ST_EXEC;
                        nxt_idx = 5'd0;
                        nxt_ready = 1'b0; // Hold input while executing
                    end else begin
                        nxt_idx = mem_addr + 5'd1;
                    end
                end
            end
            scr_pkg::ST_EXEC: begin
                if (cmd.code == `SCR_CMD_VCI) begin
                    nxt_vci = cell_mem[`SCR_OFS_SUB];
                end
                if (want_rsp) begin
                    nxt_state = scr_pkg::ST_TX;
                end else begin
                    nxt_state = scr_pkg::ST_RX;
                    nxt_ready = 1'b1;
                end
            end
            scr_pkg::ST_TX: begin
                // A full FIFO stalls here, and so stalls the input
                if (fifo_wr_ready) begin
                    if (idx_ff == `SCR_CELL_LEN - 5'd1) begin
                        nxt_state = scr_pkg::ST_RX;
                        nxt_idx = 5'd0;
                        nxt_ready = 1'b1;
                    end else begin
                        nxt_idx = idx_ff + 5'd1;
                    end
                end
            end
            default: begin
                nxt_state = scr_pkg::ST_RX;
                nxt_idx = 5'd0;
                nxt_ready = 1'b1;
            end
        endcase
    end

    // Control registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= scr_pkg::ST_RX;
            idx_ff <= 5'd0;
            vci_ff <= `SCR_VCI_RST;
            ready_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            vci_ff <= nxt_vci;
            ready_ff <= nxt_ready;
        end
    end

    // Cell buffer, data only so no reset
    always_ff @(posedge i_clk) begin
        if (mem_we) begin
            cell_mem[mem_addr] <= i_cell_byte;
        end
    end

    assign o_cell_ready = ready_ff;
    assign o_switch_vci = vci_ff;

    // ****************************************
    // Reset pulse generators
    // ****************************************
    logic [CW-1:0] sys_cnt_ff;
    logic [CW-1:0] nxt_sys_cnt;
    logic [CW-1:0] ctl_cnt_ff;
    logic [CW-1:0] nxt_ctl_cnt;
    logic sys_rst_ff;
    logic ctl_rst_ff;

    // Button reloads while held, so release follows a full hold
    always_comb begin
        nxt_sys_cnt = (sys_cnt_ff != '0) ? sys_cnt_ff - 1'b1 : sys_cnt_ff;
        nxt_ctl_cnt = (ctl_cnt_ff != '0) ? ctl_cnt_ff - 1'b1 : ctl_cnt_ff;
        if (button || exec_sys) begin
            nxt_sys_cnt = HOLD;
        end
        if (button || exec_ctl) begin
            nxt_ctl_cnt = HOLD;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_cnt_ff <= '0;
            ctl_cnt_ff <= '0;
            sys_rst_ff <= 1'b0;
            ctl_rst_ff <= 1'b0;
        end else begin
            sys_cnt_ff <= nxt_sys_cnt;
            ctl_cnt_ff <= nxt_ctl_cnt;
            sys_rst_ff <= (nxt_sys_cnt != '0);
            ctl_rst_ff <= (nxt_ctl_cnt != '0);
        end
    end

    assign o_system_reset_out = sys_rst_ff;
    assign o_controller_reset_out = ctl_rst_ff;

    // Per-port pulse, driven only by the port command
    genvar gp;
    generate
        for (gp = 0; gp < PORTS; gp++) begin : g_port
            logic [CW-1:0] cnt_ff;
            logic [CW-1:0] nxt_cnt;
            logic rst_ff;

            always_comb begin
                nxt_cnt = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
                if (exec_port[gp]) begin
                    nxt_cnt = HOLD;
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cnt_ff <= '0;
                    rst_ff <= 1'b0;
                end else begin
                    cnt_ff <= nxt_cnt;
                    rst_ff <= (nxt_cnt != '0);
                end
            end

            assign o_port_reset_out[gp] = rst_ff;
        end
    endgenerate

    // ****************************************
    // Response FIFO and output register
    // ****************************************
    logic fifo_rd_valid;
    logic fifo_rd_ready;
    scr_pkg::scr_rsp_s fifo_rd_data;
    logic rsp_valid_ff;
    logic nxt_rsp_valid;
    scr_pkg::scr_rsp_s rsp_ff;
    scr_pkg::scr_rsp_s nxt_rsp;

    scr_fifo #(
        .WIDTH($bits(scr_pkg::scr_rsp_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_rsp_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr_valid(fifo_wr_valid),
        .o_wr_ready(fifo_wr_ready),
        .i_wr_data(fifo_wr_data),
        .o_rd_valid(fifo_rd_valid),
        .i_rd_ready(fifo_rd_ready),
        .o_rd_data(fifo_rd_data)
    );

    // Output stage loads when empty or being drained
    always_comb begin
        fifo_rd_ready = !rsp_valid_ff || i_rsp_ready;
        nxt_rsp_valid = rsp_valid_ff;
        nxt_rsp = rsp_ff;
        if (fifo_rd_ready) begin
            nxt_rsp_valid = fifo_rd_valid;
            nxt_rsp = fifo_rd_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rsp_valid_ff <= 1'b0;
            rsp_ff <= '0;
        end else begin
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_ff <= nxt_rsp;
        end
    end

    assign o_rsp_valid = rsp_valid_ff;
    assign o_rsp_sop = rsp_ff.sop;
    assign o_rsp_byte = rsp_ff.data;

endmodule : scr_top

`default_nettype wire

// ==== core/scr_map.svh ====
// Constants of the management command and reset block.
// Assumes a 50 MHz system clock and a cell already matched on VPI/VCI.
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// ****************************************
// Cell layout (byte offsets in a command cell)
// ****************************************
`define SCR_HDR_LEN 5'd4
`define SCR_OFS_CMD 5'd4
`define SCR_OFS_SUB 5'd5
`define SCR_OFS_CNT 5'd6
`define SCR_OFS_DATA0 5'd7
`define SCR_CELL_LEN 5'd25

// ****************************************
// Command codes, bits 2..0 of the command byte
// ****************************************
`define SCR_CMD_CTL_RST 3'h3
`define SCR_CMD_GLB_RST 3'h4
`define SCR_CMD_PORT_RST 3'h5
`define SCR_CMD_REV 3'h6
`define SCR_CMD_VCI 3'h7

// ****************************************
// Reset values and timing
// ****************************************
`define SCR_VCI_RST 8'h00
`define SCR_REV_VAL 8'h10
`define SCR_CLK_PERIOD_NS 20
`define SCR_RST_HOLD_NS 1000
`define SCR_RST_HOLD_CYC (`SCR_RST_HOLD_NS / `SCR_CLK_PERIOD_NS)
`define SCR_FIFO_DEPTH 32

`endif

// ==== core/scr_pkg.sv ====
// Types shared by the command and reset block and its FIFO.
// Assumes the constants of scr_map.svh.
package scr_pkg;

    // ****************************************
    // Types
    // ****************************************
    // Command byte fields
    typedef struct packed {
        logic ack;
        logic poll;
        logic [2:0] spare;
        logic [2:0] code;
    } scr_cmd_byte_s;

    // Revision byte: digit before and after the point
    typedef struct packed {
        logic [3:0] major;
        logic [3:0] minor;
    } scr_rev_s;

    // One byte of a response cell
    typedef struct packed {
        logic sop;
        logic [7:0] data;
    } scr_rsp_s;

    typedef enum logic [1:0] {
        ST_RX,
        ST_EXEC,
        ST_TX
    } scr_state_e;

endpackage : scr_pkg

// ==== core/scr_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ns
`default_nettype none

module scr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic [AW:0] nxt_wr_ptr;
    logic [AW:0] nxt_rd_ptr;
    logic full;
    logic empty;
    logic do_wr;
    logic do_rd;

    // Extra pointer bit tells full from empty
    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                  (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign o_wr_ready = !full;
    assign o_rd_valid = !empty;
    assign o_rd_data = mem[rd_ptr_ff[AW-1:0]];
    assign do_wr = i_wr_valid && !full;
    assign do_rd = i_rd_ready && !empty;

    // Pointer next values
    always_comb begin
        nxt_wr_ptr = do_wr ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr = do_rd ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    end

    // Pointer registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge i_clk) begin
        if (do_wr) begin
            mem[wr_ptr_ff[AW-1:0]] <= i_wr_data;
        end
    end

endmodule : scr_fifo

`default_nettype wire

// ==== bench/scr_top_sva.sv ====
// Port checker of the command and reset block.
// Assumes binding to scr_top with the hold count it was built with.
`timescale 1ns/1ns
`default_nettype none
module scr_top_sva #(
    parameter int RST_HOLD_CYCLES = 4,
    parameter int PORTS = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reset_button_n,
    input wire logic i_cell_valid,
    input wire logic i_cell_sop,
    input wire logic [7:0] i_cell_byte,
    input wire logic o_cell_ready,
    input wire logic o_rsp_valid,
    input wire logic [7:0] o_rsp_byte,
    input wire logic i_rsp_ready,
    input wire logic [7:0] o_switch_vci,
    input wire logic o_system_reset_out,
    input wire logic o_controller_reset_out,
    input wire logic [PORTS-1:0] o_port_reset_out
);
    localparam int HOLD_P1 = RST_HOLD_CYCLES + 1;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [7:0] cmd_ff, nxt_cmd, sub_ff, nxt_sub;
    logic take, last, is_port, is_glb, is_ctl, is_vci;
    // ****************
    // Cell tracking
    // ****************
    // Byte position; stray bytes outside a cell are not counted
    always_comb begin
        take = i_cell_valid && o_cell_ready;
        last = take && !i_cell_sop && cnt_ff == 5'd24;
        is_port = last && cmd_ff[2:0] == 3'h5;
        is_glb = last && cmd_ff[2:0] == 3'h4;
        is_ctl = last && cmd_ff[2:0] == 3'h3;
        is_vci = last && cmd_ff[2:0] == 3'h7;
        nxt_cnt = cnt_ff;
        nxt_cmd = cmd_ff;
        nxt_sub = sub_ff;
        if (take && i_cell_sop) begin
            nxt_cnt = 5'd1;
        end else if (last) begin
            nxt_cnt = 5'd0;
        end else if (take && cnt_ff != 5'd0) begin
            nxt_cnt = cnt_ff + 5'd1;
        end
        if (take && !i_cell_sop && cnt_ff == 5'd4) nxt_cmd = i_cell_byte;
        if (take && !i_cell_sop && cnt_ff == 5'd5) nxt_sub = i_cell_byte;
    end
    // Tracking registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= 5'd0;
            cmd_ff <= 8'h00;
            sub_ff <= 8'h00;
        end else begin
            cnt_ff <= nxt_cnt;
            cmd_ff <= nxt_cmd;
            sub_ff <= nxt_sub;
        end
    end
    // ****************
    // Assertions
    // ****************
    a_port_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_port |-> ##2 (o_port_reset_out & sub_ff) == sub_ff) else $error("port reset missing");
    a_port_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_port && sub_ff[0] |-> ##HOLD_P1 o_port_reset_out[0] ##1 !o_port_reset_out[0])
        else $error("port reset length wrong");
    a_port_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        |(o_port_reset_out & ~$past(o_port_reset_out)) |-> $past(is_port, 2)) else $error("port reset uncommanded");
    a_vci_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_vci |-> ##2 o_switch_vci == sub_ff) else $error("vci not loaded");
    a_glb_both: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_glb |-> ##2 o_system_reset_out && o_controller_reset_out) else $error("global reset missing");
    a_ctl_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_ctl && !o_system_reset_out |-> ##2 o_controller_reset_out && !o_system_reset_out)
        else $error("controller reset wrong");
    a_btn_both: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(i_reset_button_n) |-> ##[1:4] (o_system_reset_out && o_controller_reset_out))
        else $error("button reset missing");
    a_rsp_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_byte)) else $error("reply byte dropped");
endmodule : scr_top_sva
bind scr_top scr_top_sva #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES), .PORTS(PORTS)) scr_top_sva_inst (.*);
`default_nettype wire

// ==== bench/scr_ws_model.sv ====
// Workstation model: sends command cells, takes reply bytes.
// Assumes send_cell is called just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module scr_ws_model (
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic i_cell_ready,
    input wire logic i_rsp_valid,
    input wire logic i_rsp_sop,
    input wire logic [7:0] i_rsp_byte,
    output logic o_cell_valid,
    output logic o_cell_sop,
    output logic [7:0] o_cell_byte,
    output logic o_rsp_ready
);
    logic [8:0] rq[$];
    // Quiet lines at time zero
    initial begin
        o_cell_valid = 1'b0;
        o_cell_sop = 1'b0;
        o_cell_byte = 8'hA5;
        o_rsp_ready = 1'b0;
    end
    // Random back-pressure; stall sampled at the edge to avoid a race
    always @(posedge i_clk) begin
        o_rsp_ready <= #2 !i_stall && ($urandom_range(3) != 0);
    end
    // Taken at negedge, where the values equal the next edge's
    always @(negedge i_clk) begin
        if (i_rsp_valid && o_rsp_ready) rq.push_back({i_rsp_sop, i_rsp_byte});
    end
    // One whole cell of 25 bytes, held until ready is seen
    task automatic send_cell(input logic [199:0] c);
        for (int i = 0; i < 25; i++) begin
            o_cell_valid = 1'b1;
            o_cell_sop = (i == 0);
            o_cell_byte = c[199 - 8 * i -: 8];
            while (!i_cell_ready) begin
                @(posedge i_clk);
                #2;
            end
            @(posedge i_clk);
            #2;
        end
        o_cell_valid = 1'b0;
        o_cell_sop = 1'b0;
        o_cell_byte = ~o_cell_byte; // Released line shows no stale byte
    endtask : send_cell
endmodule : scr_ws_model
`default_nettype wire

// ==== bench/scr_top_bench.sv ====
// Self-checking bench of the command and reset block.
// Assumes the workstation model drives cells and takes replies.
`timescale 1ns/1ns
`default_nettype none
module scr_top_bench;
    localparam int HOLD = 4;
    localparam logic [7:0] REV = {4'h1, 4'h3}; // Arbitrary revision 1.3
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic btn_n = 1'b1;
    logic stall = 1'b0;
    logic cv, cs, cr, rv, rs, rr, sys, ctl;
    logic [7:0] cb, rb, vci, ports, exp_vci;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    // ****************
    // Clock, design and far side
    // ****************
    always #10 i_clk = ~i_clk;
    scr_top #(.RST_HOLD_CYCLES(HOLD), .REVISION(REV)) scr_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_reset_button_n(btn_n), .i_cell_valid(cv), .i_cell_sop(cs), .i_cell_byte(cb), .o_cell_ready(cr),
        .o_rsp_valid(rv), .o_rsp_sop(rs), .o_rsp_byte(rb), .i_rsp_ready(rr), .o_switch_vci(vci),
        .o_system_reset_out(sys), .o_controller_reset_out(ctl), .o_port_reset_out(ports));
    scr_ws_model scr_ws_model_inst (.i_clk(i_clk), .i_stall(stall), .i_cell_ready(cr), .i_rsp_valid(rv),
        .i_rsp_sop(rs), .i_rsp_byte(rb), .o_cell_valid(cv), .o_cell_sop(cs), .o_cell_byte(cb), .o_rsp_ready(rr));
    // ****************
    // Checks and expectations
    // ****************
    task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_cnt(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt
    function automatic logic [8:0] exp_rsp(input logic [199:0] c, input int i);
        logic [7:0] b;
        b = c[199 - 8 * i -: 8];
        if (i == 7) b = REV;
        return {i == 0, b};
    endfunction : exp_rsp
    // Reset outputs due one cycle after execute: {system, controller, ports}
    function automatic logic [9:0] exp_rst(input logic [7:0] cmd, input logic [7:0] sub);
        case (cmd[2:0])
            3'h3: return {2'b01, 8'h00};
            3'h4: return {2'b11, 8'h00};
            3'h5: return {2'b00, sub};
            default: return 10'h000;
        endcase
    endfunction : exp_rst
    function automatic bit rsp_due(input logic [7:0] cmd);
        return cmd[2:0] == 3'h6 || (cmd[7] && cmd[2:0] >= 3'h3);
    endfunction : rsp_due
    // One cell, then its reply and the stored VCI
    task automatic run_cell(input logic [7:0] cmd, input logic [7:0] sub);
        logic [199:0] c;
        logic [9:0] er;
        c = 200'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
        c[167:160] = cmd;
        c[159:152] = sub;
        scr_ws_model_inst.rq.delete();
        er = exp_rst(cmd, sub);
        scr_ws_model_inst.send_cell(c);
        // Pulses stand from the edge after execute, so look one edge later
        repeat (2) @(posedge i_clk);
        #2;
        chk_val({1'b0, ports}, {1'b0, er[7:0]});
        chk_val({7'h00, sys, ctl}, {7'h00, er[9:8]});
        repeat (58) @(posedge i_clk);
        #2;
        chk_val({7'h00, sys, ctl} | {1'b0, ports}, 9'h000);
        chk_cnt(scr_ws_model_inst.rq.size(), rsp_due(cmd) ? 25 : 0);
        foreach (scr_ws_model_inst.rq[i]) begin
            if (i < 7 || (i == 7 && cmd[2:0] == 3'h6)) chk_val(scr_ws_model_inst.rq[i], exp_rsp(c, i));
        end
        if (cmd[2:0] == 3'h7) exp_vci = sub;
        chk_val({1'b0, vci}, {1'b0, exp_vci});
    endtask : run_cell
    task automatic stop_test;
        $display("n_fail=%0d checks_done=%0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    // Hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_fail++;
            stop_test();
        end
    end
    // Main sequence
    initial begin
        logic [7:0] sub;
        void'($urandom(32'hD52DE414));
        repeat (2) @(posedge i_clk);
        #2;
        i_rst_n = 1'b1;
        exp_vci = 8'h00;
        chk_val({cr, sys, ctl, ports[5:0]}, 9'h100);
        for (int k = 0; k < 24; k++) begin
            sub = (k == 5 || k == 15) ? 8'hFF : (k == 13) ? 8'h00 : 8'($urandom);
            run_cell({5'($urandom), k[2:0]}, sub);
        end
        btn_n = 1'b0;
        repeat (6) @(posedge i_clk);
        #2;
        chk_val({sys, ctl, ports[6:0]}, 9'h180);
        btn_n = 1'b1;
        repeat (20) @(posedge i_clk);
        #2;
        chk_val({sys, ctl, ports[6:0]}, 9'h000);
        stall = 1'b1;
        scr_ws_model_inst.rq.delete();
        scr_ws_model_inst.send_cell({32'h0, 8'h86, 160'h0});
        // One edge between cells so valid is not lowered and raised at once
        @(posedge i_clk);
        #2;
        scr_ws_model_inst.send_cell({32'h1, 8'h06, 160'h0});
        repeat (10) @(posedge i_clk);
        #2;
        chk_val({8'h00, cr}, 9'h000);
        stall = 1'b0;
        repeat (120) @(posedge i_clk);
        #2;
        chk_cnt(scr_ws_model_inst.rq.size(), 50);
        chk_val(scr_ws_model_inst.rq[25], 9'h100);
        chk_val(scr_ws_model_inst.rq[32], {1'b0, REV});
        stop_test();
    end
endmodule : scr_top_bench
`default_nettype wire
